// *** rtl/vpfs_defines.svh ***
// Register word indices, field positions, reset values and timing counts of the formatter
`ifndef VPFS_DEFINES_SVH
`define VPFS_DEFINES_SVH
// Word indices; byte address is four times the index
`define VPFS_R_CTRL    6'h00
`define VPFS_R_STATUS  6'h01
`define VPFS_R_MISM    6'h02
`define VPFS_R_PUSE    6'h03
`define VPFS_R_RZ      6'h04
`define VPFS_R_STATIC  6'h05
`define VPFS_R_PINS    6'h06
`define VPFS_R_DELAY   6'h07
`define VPFS_R_WTEDGE  6'h08
`define VPFS_R_WTCHAR  6'h09
`define VPFS_R_CADDR   6'h0A
`define VPFS_R_CD0     6'h0B
`define VPFS_R_CD1     6'h0C
`define VPFS_R_CD2     6'h0D
`define VPFS_R_SITE0   6'h10
`define VPFS_R_PMU     6'h14
`define VPFS_R_PRES    6'h15
`define VPFS_R_AUX     6'h16
// Control register bit positions
`define VPFS_C_START   0
`define VPFS_C_STOP    1
`define VPFS_C_TRIG    2
`define VPFS_C_MULTI   4
`define VPFS_C_MMS     5
// Parametric unit control bit positions
`define VPFS_P_AVG     7
`define VPFS_P_60HZ    8
`define VPFS_P_GO      9
// Reset vector period in clock cycles
`define VPFS_PER_RST   8'h0A
// Timing
`define VPFS_CLK_HZ    10000000
`define VPFS_CLK_NS    100
`define VPFS_AVG_N     64
`define VPFS_MAINS_LO_HZ 50
`define VPFS_MAINS_HI_HZ 60
`define VPFS_SPC_LO    (`VPFS_CLK_HZ / (`VPFS_MAINS_LO_HZ * `VPFS_AVG_N))
`define VPFS_SPC_HI    (`VPFS_CLK_HZ / (`VPFS_MAINS_HI_HZ * `VPFS_AVG_N))
`endif

// *** rtl/vpfs_pkg.sv ***
// Types shared by the vector formatter and sequencer
package vpfs_pkg;
  // Per-pin hardware action selected by a vector character
  typedef enum logic [2:0] {
    ACT_NOCMP, ACT_DHI, ACT_DLO, ACT_PREV, ACT_REL, ACT_CHI, ACT_CLO, ACT_CZ
  } vpfs_act_t;
  // Sequencer opcode carried by each cached vector
  typedef enum logic [2:0] {
    OP_NEXT, OP_LOOP, OP_LINF, OP_BRM, OP_WAIT, OP_HALT
  } vpfs_op_t;
  // Site sequencer state
  typedef enum logic [1:0] {S_IDLE, S_RUN, S_WAIT} vpfs_seq_t;
  // Channel use
  typedef enum logic [1:0] {U_PARAM, U_STATIC, U_PAT} vpfs_use_t;
  // Parametric unit mode
  typedef enum logic [2:0] {
    FORCE_VOLT_SENSE_CURRENT, FORCE_CURRENT_SENSE_VOLT, FORCE_VOLT_SENSE_VOLT,
    FORCE_CURRENT_SENSE_CURRENT, FLOAT_SENSE_VOLT
  } vpfs_pmu_t;
  // Avalon-MM request from the master
  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
  } vpfs_avs_req_t;
  // Avalon-MM answer to the master
  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } vpfs_avs_rsp_t;
  // One site sequencer
  typedef struct packed {
    vpfs_seq_t  st;
    logic [7:0] pc;
    logic [7:0] tick;
    logic [7:0] lcnt;
    logic [7:0] per;
    logic [7:0] start;
    logic       fail;
  } vpfs_site_t;
endpackage

// *** rtl/vpfs_top.sv ***
// Vector formatter, site sequencers and parametric unit control
`timescale 1ns/1ps
`default_nettype none
`include "vpfs_defines.svh"
module vpfs_top
  import vpfs_pkg::*;
#(
  parameter int NWT   = 32, // Waveform tables
  parameter int DEPTH = 64  // Vectors in the pattern cache
) (
  input  wire logic               clk_in,
  input  wire logic               srst_in,
  input  wire vpfs_avs_req_t      avs_req_in,
  output var  vpfs_avs_rsp_t      avs_rsp_out,
  input  wire logic [15:0]        dut_pin_in,
  input  wire logic [15:0]        dut_hiz_in,
  output var  logic [15:0]        dut_drv_out,
  output var  logic [15:0]        dut_oe_out,
  output var  logic [3:0]         hv_drv_out,
  output var  logic [3:0]         relay_out,
  output var  logic [3:0]         relay_oe_out,
  input  wire logic [15:0]        adc_data_in,
  input  wire logic               adc_valid_in,
  output var  logic               adc_start_out,
  output var  logic [3:0]         pmu_sel_out,
  output var  vpfs_pmu_t [15:0]   pmu_mode_out
);
  localparam int AW = $clog2(DEPTH);
  localparam int TW = $clog2(NWT);

  // Refuse sizes the index widths cannot serve
  if (NWT < 2 || NWT > 32 || DEPTH < 2 || DEPTH > 256) begin : g_chk
    $error("vpfs_top: NWT must be 2..32 and DEPTH 2..256");
  end

  // Whole state of the block
  typedef struct packed {
    logic                          wreq;     // Waitrequest, high when idle
    logic [31:0]                   rdata;    // Read data register
    logic                          multi;    // Four-site mode requested
    logic                          multi_module_sync_option;      // Joined to other modules
    vpfs_use_t [15:0]              pin_use;  // Channel use
    logic [15:0]                   rz;       // Return-to-zero select
    logic [15:0]                   sout;     // Static drive level
    logic [15:0]                   soe;      // Static drive enable
    logic [15:0]                   drv;      // Pin drive level
    logic [15:0]                   oe;       // Pin drive enable
    logic [15:0]                   last;     // Last forced level
    logic [15:0]                   mism;     // Sticky mismatch flags
    logic [15:0][7:0]              odly;     // Output delay, ns
    logic [15:0][7:0]              rdly;     // Receive delay, ns
    logic [NWT-1:0][23:0]          wedge;    // Receive, edge 2, edge 1 in ns
    logic [NWT-1:0][15:0][2:0]     wact;     // Character to action map
    logic [DEPTH-1:0][87:0]        cache;    // Pattern cache
    logic [7:0]                    caddr;    // Cache access pointer
    vpfs_site_t [3:0]              site;     // Site sequencers
    logic [15:0]                   pin_s1;   // Pin synchroniser stage 1
    logic [15:0]                   pin_s2;   // Pin synchroniser stage 2
    logic [15:0]                   hiz_s1;   // High-impedance sense stage 1
    logic [15:0]                   hiz_s2;   // High-impedance sense stage 2
    logic [15:0]                   adc_s1;   // Converter data stage 1
    logic [15:0]                   adc_s2;   // Converter data stage 2
    logic [2:0]                    av;       // Converter valid sync and edge
    vpfs_pmu_t [15:0]              pmode;    // Parametric mode per pin
    logic [3:0]                    psel;     // Pin on the converter
    logic                          pavg;     // Averaging enable
    logic                          p60;      // 60 Hz spacing
    logic                          pbusy;    // Measurement running
    logic                          adst;     // Conversion start pulse
    logic [6:0]                    pcnt;     // Samples taken
    logic [6:0]                    pnis;     // Conversions issued
    logic [11:0]                   pspc;     // Spacing countdown
    logic [21:0]                   pacc;     // Sample sum
    logic [15:0]                   pres;     // Measurement result
    logic [3:0]                    hv;       // High-voltage drive per site
    logic [3:0]                    rly;      // Relay pull per site
  } vpfs_state_t;

  vpfs_state_t q;   // Registered state
  vpfs_state_t d;   // Next state

  logic       wr_go;  // Write taken this edge
  logic [5:0] widx;   // Word index of the request
  logic [31:0] wd;    // Write data
  logic       multi;  // Four-site mode in effect

  assign widx  = avs_req_in.address[7:2];
  assign wd    = avs_req_in.writedata;
  assign wr_go = avs_req_in.write && !q.wreq;
  assign multi = q.multi && !q.multi_module_sync_option;

  // Cached vector at an index, zero past the end
  function automatic logic [87:0] vec(input logic [7:0] idx);
    vec = (int'(idx) < DEPTH) ? q.cache[idx[AW-1:0]] : 88'h0;
  endfunction

  // Edge falls in this cycle of the period
  function automatic logic hit(input logic [7:0] ns, input logic [7:0] dly,
                               input logic [7:0] t);
    hit = ((9'(ns) + 9'(dly)) / 9'(`VPFS_CLK_NS)) == 9'(t);
  endfunction

  // Next-state logic
  always_comb begin
    vpfs_site_t  cs;
    logic [87:0] v;
    logic [TW-1:0] tb;
    vpfs_act_t   a;
    logic [23:0] e;
    logic [3:0]  smiss;
    logic        miss;
    logic        fn;
    logic [7:0]  nx;
    int          s;
    cs = '0;
    v = '0;
    tb = '0;
    a = ACT_NOCMP;
    e = '0;
    smiss = '0;
    miss = 1'b0;
    fn = 1'b0;
    nx = '0;
    s = 0;
    d = q;
    d.adst = 1'b0;
    // Synchronisers for pins and converter
    d.pin_s1 = dut_pin_in;
    d.pin_s2 = q.pin_s1;
    d.hiz_s1 = dut_hiz_in;
    d.hiz_s2 = q.hiz_s1;
    d.adc_s1 = adc_data_in;
    d.adc_s2 = q.adc_s1;
    d.av = {q.av[1], q.av[0], adc_valid_in};
    // Mismatch clear by writing ones, before new mismatches set
    if (wr_go && widx == `VPFS_R_MISM) begin
      d.mism = q.mism & ~wd[15:0];
    end
    // Pin formatter
    for (int p = 0; p < 16; p++) begin
      s = multi ? p / 4 : 0;
      cs = q.site[s];
      v = vec(cs.pc);
      tb = v[64 +: TW];
      a = vpfs_act_t'(q.wact[tb][v[4*p +: 4]]);
      e = q.wedge[tb];
      miss = 1'b0;
      unique case (q.pin_use[p])
        U_STATIC: begin
          d.drv[p] = q.sout[p];
          d.oe[p] = q.soe[p];
        end
        U_PAT: begin
          if (cs.st == S_RUN) begin
            // First drive edge sets the level or releases
            if (hit(e[7:0], q.odly[p], cs.tick)) begin
              unique case (a)
                ACT_DHI: begin
                  d.drv[p] = 1'b1;
                  d.oe[p] = 1'b1;
                  d.last[p] = 1'b1;
                end
                ACT_DLO: begin
                  d.drv[p] = 1'b0;
                  d.oe[p] = 1'b1;
                  d.last[p] = 1'b0;
                end
                ACT_PREV: begin
                  d.drv[p] = q.last[p];
                  d.oe[p] = 1'b1;
                end
                default: d.oe[p] = 1'b0;
              endcase
            end
            // Second drive edge returns to zero
            if (q.rz[p] && hit(e[15:8], q.odly[p], cs.tick)) begin
              d.drv[p] = 1'b0;
            end
            // Receive edge compares the sampled pin
            if (hit(e[23:16], q.rdly[p], cs.tick)) begin
              unique case (a)
                ACT_CHI: miss = !q.pin_s2[p] || q.hiz_s2[p];
                ACT_CLO: miss = q.pin_s2[p] || q.hiz_s2[p];
                ACT_CZ:  miss = !q.hiz_s2[p];
                default: miss = 1'b0;
              endcase
            end
          end
        end
        default: begin
          // Parametric use keeps the digital driver off
          d.drv[p] = 1'b0;
          d.oe[p] = 1'b0;
        end
      endcase
      d.mism[p] = d.mism[p] | miss;
      smiss[s] = smiss[s] | miss;
    end
    // Site sequencers
    for (int k = 0; k < 4; k++) begin
      cs = q.site[k];
      v = vec(cs.pc);
      fn = cs.fail | smiss[k];
      nx = cs.pc + 8'h01;
      if (cs.st == S_RUN) begin
        d.site[k].fail = fn;
        d.site[k].tick = cs.tick + 8'h01;
        if (9'(cs.tick) + 9'h001 >= 9'(cs.per)) begin
          d.site[k].tick = 8'h00;
          d.site[k].fail = 1'b0;
          unique case (vpfs_op_t'(v[71:69]))
            OP_LOOP: begin
              if (cs.lcnt != v[79:72]) begin
                d.site[k].lcnt = cs.lcnt + 8'h01;
                d.site[k].pc = v[87:80];
              end else begin
                d.site[k].lcnt = 8'h00;
                d.site[k].pc = nx;
              end
            end
            OP_LINF: d.site[k].pc = v[87:80];
            OP_BRM: d.site[k].pc = fn ? nx : v[87:80];
            OP_WAIT: begin
              d.site[k].pc = nx;
              d.site[k].st = S_WAIT;
            end
            OP_HALT: d.site[k].st = S_IDLE;
            OP_NEXT: d.site[k].pc = nx;
            default: d.site[k].st = S_IDLE;
          endcase
          // Running off the end of the cache stops the site, except at DEPTH 256 where pc wraps to 0
          if (d.site[k].pc == nx && 9'(nx) >= 9'(DEPTH)) begin
            d.site[k].st = S_IDLE;
          end
        end
      end
      if (k != 0 && !multi) begin
        d.site[k].st = S_IDLE;
      end
    end
    // Parametric measurement engine
    if (q.pbusy) begin
      if (q.pspc != 12'h000) begin
        d.pspc = q.pspc - 12'h001;
      end
      if (q.pspc == 12'h001) begin
        d.adst = 1'b1;
        d.pnis = q.pnis + 7'h01;
        d.pspc = (q.pnis + 7'h01 < 7'(`VPFS_AVG_N))
               ? (q.p60 ? 12'(`VPFS_SPC_HI) : 12'(`VPFS_SPC_LO)) : 12'h000;
      end
      if (q.av[1] && !q.av[2]) begin
        d.pacc = q.pacc + 22'(q.adc_s2);
        d.pcnt = q.pcnt + 7'h01;
        if (!q.pavg) begin
          d.pbusy = 1'b0;
          d.pres = q.adc_s2;
        end else if (q.pcnt == 7'(`VPFS_AVG_N - 1)) begin
          d.pbusy = 1'b0;
          d.pres = d.pacc[21:6];
        end
      end
    end
    // Register writes
    if (wr_go) begin
      unique case (widx)
        `VPFS_R_CTRL: begin
          d.multi = wd[`VPFS_C_MULTI];
          d.multi_module_sync_option = wd[`VPFS_C_MMS];
          for (int k = 0; k < 4; k++) begin
            if (wd[`VPFS_C_TRIG] && q.site[k].st == S_WAIT) begin
              d.site[k].st = S_RUN;
            end
            if (wd[`VPFS_C_START] && (k == 0 || multi)) begin
              d.site[k].st = S_RUN;
              d.site[k].pc = q.site[k].start;
              d.site[k].tick = 8'h00;
              d.site[k].lcnt = 8'h00;
              d.site[k].fail = 1'b0;
            end
            if (wd[`VPFS_C_STOP]) begin
              d.site[k].st = S_IDLE;
            end
          end
        end
        `VPFS_R_PUSE: begin
          for (int p = 0; p < 16; p++) begin
            d.pin_use[p] = vpfs_use_t'(wd[2*p +: 2]);
          end
        end
        `VPFS_R_RZ: d.rz = wd[15:0];
        `VPFS_R_STATIC: begin
          d.sout = wd[15:0];
          d.soe = wd[31:16];
        end
        `VPFS_R_DELAY: begin
          d.odly[wd[3:0]] = wd[15:8];
          d.rdly[wd[3:0]] = wd[23:16];
        end
        `VPFS_R_WTEDGE: begin
          if (int'(wd[4:0]) < NWT) begin
            d.wedge[wd[TW-1:0]] = wd[31:8];
          end
        end
        `VPFS_R_WTCHAR: begin
          if (int'(wd[4:0]) < NWT && wd[8:5] != 4'h0) begin
            d.wact[wd[TW-1:0]][wd[8:5]] = wd[11:9];
          end
        end
        `VPFS_R_CADDR: d.caddr = wd[7:0];
        `VPFS_R_CD0, `VPFS_R_CD1, `VPFS_R_CD2: begin
          if (int'(q.caddr) < DEPTH) begin
            if (widx == `VPFS_R_CD0) d.cache[q.caddr[AW-1:0]][31:0] = wd;
            else if (widx == `VPFS_R_CD1) d.cache[q.caddr[AW-1:0]][63:32] = wd;
            else d.cache[q.caddr[AW-1:0]][87:64] = wd[23:0];
          end
        end
        `VPFS_R_PMU: begin
          d.psel = wd[3:0];
          if (wd[6:4] <= 3'h4) begin
            d.pmode[wd[3:0]] = vpfs_pmu_t'(wd[6:4]);
          end
          d.pavg = wd[`VPFS_P_AVG];
          d.p60 = wd[`VPFS_P_60HZ];
          if (wd[`VPFS_P_GO] && !q.pbusy) begin
            d.pbusy = 1'b1;
            d.adst = 1'b1;
            d.pnis = 7'h01;
            d.pcnt = 7'h00;
            d.pacc = 22'h000000;
            d.pspc = !wd[`VPFS_P_AVG] ? 12'h000
                   : (wd[`VPFS_P_60HZ] ? 12'(`VPFS_SPC_HI) : 12'(`VPFS_SPC_LO));
          end
        end
        `VPFS_R_AUX: begin
          d.hv = wd[3:0];
          d.rly = wd[7:4];
        end
        default: begin
          if (widx[5:2] == `VPFS_R_SITE0 >> 2) begin
            d.site[widx[1:0]].per = wd[7:0];
            d.site[widx[1:0]].start = wd[15:8];
          end
        end
      endcase
    end
    // Bus handshake: one waited cycle, then the answer
    d.wreq = !((avs_req_in.read || avs_req_in.write) && q.wreq);
    if (avs_req_in.read && q.wreq) begin
      unique case (widx)
        `VPFS_R_CTRL: d.rdata = {26'h0, q.multi_module_sync_option, q.multi, 4'h0};
        `VPFS_R_STATUS: d.rdata = {8'h0, q.site[0].pc, 4'h0,
                                    q.site[3].fail, q.site[2].fail, q.site[1].fail,
                                    q.site[0].fail, q.site[3].st, q.site[2].st,
                                    q.site[1].st, q.site[0].st};
        `VPFS_R_MISM: d.rdata = {16'h0, q.mism};
        `VPFS_R_PUSE: d.rdata = q.pin_use;
        `VPFS_R_RZ: d.rdata = {16'h0, q.rz};
        `VPFS_R_STATIC: d.rdata = {q.soe, q.sout};
        `VPFS_R_PINS: d.rdata = {q.hiz_s2, q.pin_s2};
        `VPFS_R_CADDR: d.rdata = {24'h0, q.caddr};
        `VPFS_R_PMU: d.rdata = {22'h0, q.pbusy, q.p60, q.pavg, q.pmode[q.psel], q.psel};
        `VPFS_R_PRES: d.rdata = {15'h0, q.pbusy, q.pres};
        `VPFS_R_AUX: d.rdata = {24'h0, q.rly, q.hv};
        default: begin
          d.rdata = (widx[5:2] == `VPFS_R_SITE0 >> 2)
                  ? {16'h0, q.site[widx[1:0]].start, q.site[widx[1:0]].per} : 32'h0;
        end
      endcase
    end
  end

  // State register with synchronous reset
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      q <= '0;
      q.wreq <= 1'b1;
      for (int k = 0; k < 4; k++) begin
        q.site[k].per <= `VPFS_PER_RST;
      end
    end else begin
      q <= d;
    end
  end

  // Outputs straight from state, except relay_out which is tied low
  assign avs_rsp_out   = '{readdata: q.rdata, waitrequest: q.wreq};
  assign dut_drv_out   = q.drv;
  assign dut_oe_out    = q.oe;
  assign hv_drv_out    = q.hv;
  assign relay_out     = 4'h0;
  assign relay_oe_out  = q.rly;
  assign adc_start_out = q.adst;
  assign pmu_sel_out   = q.psel;
  assign pmu_mode_out  = q.pmode;

  // Checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);

  logic          mclr;  // Mismatch clear write
  logic          ctlw;  // Control write
  logic          cd0w;  // Cache low word write in range
  logic [AW-1:0] cidx;  // Cache pointer as index
  assign mclr = wr_go && widx == `VPFS_R_MISM;
  assign ctlw = wr_go && widx == `VPFS_R_CTRL;
  assign cd0w = wr_go && widx == `VPFS_R_CD0 && int'(q.caddr) < DEPTH;
  assign cidx = q.caddr[AW-1:0];

  mism_sticky_a: assert property (!$past(mclr) |-> ((q.mism & $past(q.mism)) == $past(q.mism)))
    else $error("mismatch flag lost without a clear");
  param_release_a: assert property (q.pin_use[0] == U_PARAM |=> !dut_oe_out[0])
    else $error("parametric pin still driven");
  site_single_a: assert property (!multi |=> q.site[1].st == S_IDLE && q.site[3].st == S_IDLE)
    else $error("extra site running in single-site mode");
  mms_single_a: assert property (q.multi_module_sync_option && $past(q.multi_module_sync_option) |-> q.site[2].st == S_IDLE)
    else $error("site running while joined to other modules");
  wait_hold_a: assert property (q.site[0].st == S_WAIT && !ctlw |=> q.site[0].st == S_WAIT)
    else $error("site left trigger wait without trigger");
  cache_write_a: assert property (cd0w |=> q.cache[$past(cidx)][31:0] == $past(wd))
    else $error("cache rewrite not stored");
  pmu_start_a: assert property ($rose(q.pbusy) |-> adc_start_out)
    else $error("measurement began without conversion");
  pmu_shared_a: assert property (adc_start_out |-> q.pbusy ##1 !adc_start_out)
    else $error("conversion started outside a measurement");
endmodule
`default_nettype wire

// *** verif/vpfs_dut_model.sv ***
// Behavioural pins of the device under test facing the formatter
`timescale 1ns/1ps
`default_nettype none
module vpfs_dut_model (
  input  wire logic [15:0] drv_in,   // Tester drive level
  input  wire logic [15:0] oe_in,    // Tester drive enable
  input  wire logic [15:0] resp_in,  // Level the device drives on released pins
  input  wire logic [15:0] float_in, // Released pins the device leaves floating
  output var  logic [15:0] pin_out,  // Level seen on each pin
  output var  logic [15:0] hiz_out   // Pin seen floating
);
  // Tester wins where it drives, the device answers elsewhere
  assign pin_out = (oe_in & drv_in) | (~oe_in & resp_in);
  // A pin floats only when neither side drives it
  assign hiz_out = ~oe_in & float_in;
endmodule
`default_nettype wire

// *** verif/vpfs_top_tb.sv ***
// Self-checking testbench for the vector formatter and sequencer
`timescale 1ns/1ps
`default_nettype none
`include "vpfs_defines.svh"
module vpfs_top_tb;
  import vpfs_pkg::*;
  logic             clk_in;      // 10 MHz clock
  logic             srst_in;     // Synchronous reset
  vpfs_avs_req_t    req;         // Bus request
  vpfs_avs_rsp_t    rsp;         // Bus answer
  logic [15:0]      pin, hiz, drv, oe;
  logic [15:0]      resp, flt;   // Device side answers
  logic [3:0]       hv, rly, rly_oe, sel;
  logic             adc_start;
  logic [15:0]      adc;         // Converter result toward the block
  logic             adc_v;       // Converter result ready
  vpfs_pmu_t [15:0] mode;
  int               fail_count;  // Mismatches
  int               n_checks;    // Comparisons
  logic [31:0]      rd;          // Last read word
  logic [31:0]      cv [6];      // Cached vectors, CD0..CD2 per vector
  int               n;
  // Design under test
  vpfs_top #(.NWT(32), .DEPTH(64)) vpfs_top_i (.clk_in(clk_in), .srst_in(srst_in),
    .avs_req_in(req), .avs_rsp_out(rsp), .dut_pin_in(pin), .dut_hiz_in(hiz),
    .dut_drv_out(drv), .dut_oe_out(oe), .hv_drv_out(hv), .relay_out(rly),
    .relay_oe_out(rly_oe), .adc_data_in(adc), .adc_valid_in(adc_v),
    .adc_start_out(adc_start), .pmu_sel_out(sel), .pmu_mode_out(mode));
  // Far side pins
  vpfs_dut_model vpfs_dut_model_i (.drv_in(drv), .oe_in(oe), .resp_in(resp),
    .float_in(flt), .pin_out(pin), .hiz_out(hiz));
  // Clock
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  // Print the verdict and stop
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Word comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_in);
    req <= '{read: ~wr, write: wr, address: {idx, 2'b00}, writedata: d};
    do begin
      @(posedge clk_in);
      k++;
    end while (rsp.waitrequest !== 1'b0 && k < 50);
    if (k >= 50) fail_count++;
    rd = rsp.readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask
  // Readback, unmapped address and site auxiliary outputs
  task automatic t_regs();
    bus(1'b1, `VPFS_R_RZ, 32'h0000_8001);
    bus(1'b0, `VPFS_R_RZ, 32'h0);
    chk(rd & 32'hFFFF, 32'h8001, "rz readback");
    bus(1'b0, 6'h3F, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    bus(1'b1, `VPFS_R_AUX, 32'h0000_00A5);
    repeat (2) @(posedge clk_in);
    chk({hv, rly_oe, rly}, 12'h5A0, "aux outputs");
  endtask
  // Every parametric mode on a different pin
  task automatic t_pmu();
    for (int m = 0; m < 5; m++) begin
      bus(1'b1, `VPFS_R_PMU, 32'((m << 4) | (m + 3)));
      repeat (2) @(posedge clk_in);
      chk({sel, mode[m + 3]}, 32'(((m + 3) << 3) | m), "pmu mode");
    end
  endtask
  // Static digital use of one pin
  task automatic t_static();
    bus(1'b1, `VPFS_R_PUSE, 32'hAAAA_A6AA);
    bus(1'b1, `VPFS_R_STATIC, 32'h0020_0020);
    repeat (4) @(posedge clk_in);
    chk({oe[5], drv[5]}, 2'b11, "static drive");
    bus(1'b0, `VPFS_R_PINS, 32'h0);
    chk(rd & 32'h0010_0020, 32'h0010_0020, "pin readback");
  endtask
  // Two vectors: pulse, compares, previous-state drive, halt
  task automatic t_pattern();
    logic [27:0] amap; // Action of characters 1..7, one nibble each
    amap = 28'h1567234;
    cv = '{32'h7054_0321, 32'h1, 32'h0, 32'h0, 32'h6, 32'h0000_00A0};
    bus(1'b1, `VPFS_R_PUSE, 32'hAAAA_AAAA);
    bus(1'b1, `VPFS_R_RZ, 32'h0000_0001);
    bus(1'b1, `VPFS_R_WTEDGE, 32'hC8FA_3200);
    for (int c = 1; c < 8; c++) begin
      bus(1'b1, `VPFS_R_WTCHAR, 32'((amap >> (28 - 4 * c) & 7) << 9 | c << 5));
    end
    for (int v = 0; v < 2; v++) begin
      bus(1'b1, `VPFS_R_CADDR, 32'(v));
      bus(1'b1, `VPFS_R_CD0, cv[3 * v]);
      bus(1'b1, `VPFS_R_CD1, cv[3 * v + 1]);
      bus(1'b1, `VPFS_R_CD2, cv[3 * v + 2]);
    end
    bus(1'b1, `VPFS_R_CTRL, 32'h1);
    for (n = 0; n < 100 && drv[0] !== 1'b1; n++) @(posedge clk_in);
    chk({oe[5], drv[5], oe[7]}, 3'b100, "drive low and release");
    for (n = 0; n < 100 && drv[0] !== 1'b0; n++) @(posedge clk_in);
    chk(n, 2, "rz pulse width");
    repeat (10) @(posedge clk_in);
    chk({oe[8], drv[8], oe[0]}, 3'b110, "previous level kept");
    repeat (20) @(posedge clk_in);
    bus(1'b0, `VPFS_R_MISM, 32'h0);
    chk(rd & 32'hFFFF, 32'h0002, "mismatch flags");
    bus(1'b0, `VPFS_R_STATUS, 32'h0);
    chk(rd & 32'h3, 32'h0, "site halted");
    bus(1'b1, `VPFS_R_MISM, 32'h2);
    bus(1'b0, `VPFS_R_MISM, 32'h0);
    chk(rd & 32'hFFFF, 32'h0, "mismatch cleared");
    // Live rewrite of the second vector into a trigger wait
    bus(1'b1, `VPFS_R_CADDR, 32'h1);
    bus(1'b1, `VPFS_R_CD2, 32'h0000_0080);
    bus(1'b1, `VPFS_R_CTRL, 32'h1);
    repeat (30) @(posedge clk_in);
    bus(1'b0, `VPFS_R_STATUS, 32'h0);
    chk(rd & 32'h3, 32'h2, "trigger wait");
    bus(1'b1, `VPFS_R_CTRL, 32'h4);
    bus(1'b0, `VPFS_R_STATUS, 32'h0);
    chk(rd & 32'h00FF_0003, 32'h0002_0001, "trigger resumes");
  endtask
  // Single conversion, then the spacing of averaged conversions
  task automatic t_meas();
    bus(1'b1, `VPFS_R_PMU, 32'h0000_0200);
    @(posedge clk_in);
    chk(adc_start, 1'b1, "conversion start");
    adc <= 16'h1234;
    adc_v <= 1'b1;
    repeat (4) @(posedge clk_in);
    adc_v <= 1'b0;
    bus(1'b0, `VPFS_R_PRES, 32'h0);
    chk(rd, 32'h0000_1234, "single result");
    bus(1'b1, `VPFS_R_PMU, 32'h0000_0280);
    @(posedge clk_in);
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (adc_start !== 1'b1 && n < 5000);
    chk(n, `VPFS_SPC_LO, "averaging spacing");
  endtask
  // Watchdog
  initial begin
    #(20000 * 100);
    fail_count++;
    results();
  end
  // Main sequence
  initial begin
    fail_count = 0;
    n_checks = 0;
    req = '0;
    adc = 16'h0000;
    adc_v = 1'b0;
    resp = 16'h0000;
    flt = 16'h0010;
    srst_in = 1'b1;
    repeat (2) @(posedge clk_in);
    srst_in <= 1'b0;
    t_regs();
    t_pmu();
    t_static();
    t_pattern();
    t_meas();
    results();
  end
endmodule
`default_nettype wire
